// File: core/smc_pkg.sv
// constants, types and clock-map layout of the sleep mode clock gating block
package smc_pkg;

  // control register layout
  localparam int unsigned SMC_ARM_BIT = 5;
  localparam int unsigned SMC_MODE_B1 = 4;
  localparam int unsigned SMC_MODE_B0 = 3;
  localparam int unsigned SMC_MODE_B2 = 2;
  localparam logic [7:0] SMC_CTRL_RST = 8'h00;

  // sleep mode codes
  localparam logic [2:0] SMC_M_IDLE = 3'h0;
  localparam logic [2:0] SMC_M_NOISE = 3'h1;
  localparam logic [2:0] SMC_M_PDOWN = 3'h2;
  localparam logic [2:0] SMC_M_PSAVE = 3'h3;
  localparam logic [2:0] SMC_M_RSV4 = 3'h4;
  localparam logic [2:0] SMC_M_RSV5 = 3'h5;
  localparam logic [2:0] SMC_M_STBY = 3'h6;
  localparam logic [2:0] SMC_M_XSTBY = 3'h7;

  // timing counts in clock cycles
  localparam logic [15:0] SMC_HALT_CYC = 16'h0004;
  localparam logic [15:0] SMC_STBY_WAKE_CYC = 16'h0006;

  // clock-map bit positions
  localparam int unsigned SMC_CK_CORE = 6;
  localparam int unsigned SMC_CK_NVM = 5;
  localparam int unsigned SMC_CK_PERIPH = 4;
  localparam int unsigned SMC_CK_CONV = 3;
  localparam int unsigned SMC_CK_ASYNC = 2;
  localparam int unsigned SMC_CK_OSC = 1;
  localparam int unsigned SMC_CK_TOSC = 0;

  // controller states, one-hot
  typedef enum logic [3:0] {
    SMC_RUN = 4'h1,
    SMC_SLEEP = 4'h2,
    SMC_START = 4'h4,
    SMC_HALT = 4'h8
  } smc_state_t;

endpackage

// File: core/smc_wake_if.sv
// wake-source bundle between the controller and its wake filter
`timescale 1ns/10ps
interface smc_wake_if;
  logic sleeping;
  logic [2:0] mode;
  logic async_sel;
  logic irq_any;
  logic adc_done;
  logic twi_match;
  logic spm_ee_rdy;
  logic [7:0] ext_irq;
  logic [3:0] ext_level_hi;
  logic t0_ovf;
  logic t0_cmp;
  logic t0_ovf_en;
  logic t0_cmp_en;
  logic global_ie;
  logic wake;

  modport ctrl (
    output sleeping, mode, async_sel, irq_any, adc_done, twi_match,
    output spm_ee_rdy, ext_irq, ext_level_hi, t0_ovf, t0_cmp,
    output t0_ovf_en, t0_cmp_en, global_ie,
    input wake
  );
  modport filt (
    input sleeping, mode, async_sel, irq_any, adc_done, twi_match,
    input spm_ee_rdy, ext_irq, ext_level_hi, t0_ovf, t0_cmp,
    input t0_ovf_en, t0_cmp_en, global_ie,
    output wake
  );
endinterface

// File: core/smc_wake_filter.sv
// per-mode wake-source filter, registered wake request
`timescale 1ns/10ps
module smc_wake_filter (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // wake bundle
  smc_wake_if.filt wk
);

  logic ext_ok;
  logic t0_ok;
  logic wake_nxt;
  logic wake_r;

  // ext line filter: low lines any, high lines level only
  assign ext_ok = (|wk.ext_irq[3:0]) | (|(wk.ext_irq[7:4] & wk.ext_level_hi));

  // timer0 needs its own enable and global enable
  assign t0_ok = wk.global_ie &
                 ((wk.t0_ovf & wk.t0_ovf_en) | (wk.t0_cmp & wk.t0_cmp_en));

  // source selection by the latched sleep mode
  always_comb begin
    wake_nxt = 1'b0;
    case (wk.mode)
      smc_pkg::SMC_M_IDLE: wake_nxt = wk.irq_any | wk.twi_match;
      smc_pkg::SMC_M_NOISE: wake_nxt = wk.adc_done | wk.twi_match | t0_ok |
                                      wk.spm_ee_rdy | ext_ok;
      smc_pkg::SMC_M_PDOWN,
      smc_pkg::SMC_M_STBY: wake_nxt = wk.twi_match | ext_ok;
      // timer0 only alive with async select
      smc_pkg::SMC_M_PSAVE,
      smc_pkg::SMC_M_XSTBY: wake_nxt = wk.twi_match | ext_ok |
                                      (t0_ok & wk.async_sel);
      default: wake_nxt = 1'b0;
    endcase
    // address match counts everywhere, gated only by sleeping
    wake_nxt = wake_nxt & wk.sleeping;
  end

  // one stage so the controller sees a clean level
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= wake_nxt;
    end
  end

  assign wk.wake = wake_r;

endmodule

// File: core/smc_sleep_ctrl.sv
// sleep mode controller: mode entry, clock gating and wake sequencing
`timescale 1ns/10ps
module smc_sleep_ctrl (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // control register access
  input wire logic ctrl_wr_i,
  input wire logic [7:0] ctrl_wdata_i,
  // core handshake
  input wire logic sleep_instr_i,
  // clock source configuration
  input wire logic xtal_source_i,
  input wire logic [15:0] startup_ck_i,
  input wire logic timer0_async_select_i,
  input wire logic adc_en_i,
  // interrupt wake sources
  input wire logic irq_any_i,
  input wire logic adc_done_i,
  input wire logic twi_match_i,
  input wire logic spm_ee_rdy_i,
  input wire logic [7:0] ext_lines_i,
  input wire logic [3:0] ext_level_hi_i,
  input wire logic t0_ovf_i,
  input wire logic t0_cmp_i,
  input wire logic t0_ovf_en_i,
  input wire logic t0_cmp_en_i,
  input wire logic global_ie_i,
  // reset wake sources
  input wire logic ext_reset_i,
  input wire logic wdt_reset_i,
  input wire logic bod_reset_i,
  // clock domain enables
  output logic core_clk_en_o,
  output logic nvm_clk_en_o,
  output logic periph_clk_en_o,
  output logic conv_clk_en_o,
  output logic async_clk_en_o,
  output logic main_osc_en_o,
  output logic timer_osc_en_o,
  // core and status
  output logic [7:0] ctrl_rdata_o,
  output logic core_halt_o,
  output logic sleeping_o,
  output logic irq_resume_o,
  output logic reset_vec_o,
  output logic adc_start_o,
  output logic async_undef_o
);

  smc_wake_if wk ();

  logic [7:0] ctrl_r;
  logic arm;
  logic [2:0] sel_mode;
  logic mode_ok;
  logic sleep_go;
  logic rst_evt;
  logic [2:0] mode_r;
  logic [2:0] mode_nxt;
  smc_pkg::smc_state_t state_r;
  smc_pkg::smc_state_t state_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [15:0] wake_delay;
  logic [6:0] ck_nxt;
  logic [6:0] ck_r;
  logic halt_r;
  logic resume_r;
  logic rvec_r;
  logic adc_r;
  logic undef_r;
  logic sleeping_r;

  // clock map of one mode; outside sleep all run but the timer osc, which follows as0
  function automatic logic [6:0] clk_map(input logic [2:0] m,
                                         input logic as0,
                                         input logic asleep);
    logic [6:0] v;
    v = 7'h00;
    if (!asleep) begin
      v = 7'h7e;
      v[smc_pkg::SMC_CK_TOSC] = as0;
    end else begin
      case (m)
        // idle keeps all but core and nvm
        smc_pkg::SMC_M_IDLE: begin
          v[smc_pkg::SMC_CK_PERIPH] = 1'b1;
          v[smc_pkg::SMC_CK_CONV] = 1'b1;
          v[smc_pkg::SMC_CK_ASYNC] = 1'b1;
          v[smc_pkg::SMC_CK_OSC] = 1'b1;
          v[smc_pkg::SMC_CK_TOSC] = as0;
        end
        smc_pkg::SMC_M_NOISE: begin
          v[smc_pkg::SMC_CK_CONV] = 1'b1;
          v[smc_pkg::SMC_CK_ASYNC] = 1'b1;
          v[smc_pkg::SMC_CK_OSC] = 1'b1;
          v[smc_pkg::SMC_CK_TOSC] = as0;
        end
        smc_pkg::SMC_M_PDOWN: v = 7'h00;
        smc_pkg::SMC_M_PSAVE: begin
          v[smc_pkg::SMC_CK_ASYNC] = as0;
          v[smc_pkg::SMC_CK_TOSC] = as0;
        end
        smc_pkg::SMC_M_STBY: v[smc_pkg::SMC_CK_OSC] = 1'b1;
        // extended standby adds the async timer
        smc_pkg::SMC_M_XSTBY: begin
          v[smc_pkg::SMC_CK_OSC] = 1'b1;
          v[smc_pkg::SMC_CK_ASYNC] = as0;
          v[smc_pkg::SMC_CK_TOSC] = as0;
        end
        default: v = 7'h00;
      endcase
    end
    return v;
  endfunction

  // field extraction, mode bits are not in natural order
  assign arm = ctrl_r[smc_pkg::SMC_ARM_BIT];
  assign sel_mode = {ctrl_r[smc_pkg::SMC_MODE_B2],
                     ctrl_r[smc_pkg::SMC_MODE_B1],
                     ctrl_r[smc_pkg::SMC_MODE_B0]};

  // standby codes need a crystal source
  always_comb begin
    mode_ok = 1'b1;
    case (sel_mode)
      smc_pkg::SMC_M_RSV4,
      smc_pkg::SMC_M_RSV5: mode_ok = 1'b0;
      smc_pkg::SMC_M_STBY,
      smc_pkg::SMC_M_XSTBY: mode_ok = xtal_source_i;
      default: mode_ok = 1'b1;
    endcase
  end

  // sleep only when armed at the instruction
  assign sleep_go = sleep_instr_i & arm & mode_ok &
                    (state_r == smc_pkg::SMC_RUN);

  // any reset source counts while asleep or waking
  assign rst_evt = ext_reset_i | wdt_reset_i | bod_reset_i;

  // start-up length per mode of the latched sleep
  always_comb begin
    wake_delay = 16'h0000;
    case (mode_r)
      // oscillator never stopped, no start-up needed
      smc_pkg::SMC_M_IDLE,
      smc_pkg::SMC_M_NOISE: wake_delay = 16'h0000;
      smc_pkg::SMC_M_PDOWN,
      smc_pkg::SMC_M_PSAVE: wake_delay = startup_ck_i;
      smc_pkg::SMC_M_STBY,
      smc_pkg::SMC_M_XSTBY: wake_delay = smc_pkg::SMC_STBY_WAKE_CYC;
      default: wake_delay = 16'h0000;
    endcase
  end

  // bundle to the wake filter
  assign wk.sleeping = (state_r == smc_pkg::SMC_SLEEP);
  assign wk.mode = mode_r;
  assign wk.async_sel = timer0_async_select_i;
  assign wk.irq_any = irq_any_i;
  assign wk.adc_done = adc_done_i;
  assign wk.twi_match = twi_match_i;
  assign wk.spm_ee_rdy = spm_ee_rdy_i;
  assign wk.ext_irq = ext_lines_i;
  assign wk.ext_level_hi = ext_level_hi_i;
  assign wk.t0_ovf = t0_ovf_i;
  assign wk.t0_cmp = t0_cmp_i;
  assign wk.t0_ovf_en = t0_ovf_en_i;
  assign wk.t0_cmp_en = t0_cmp_en_i;
  assign wk.global_ie = global_ie_i;

  smc_wake_filter u_filt (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .wk(wk)
  );

  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    mode_nxt = mode_r;
    case (state_r)
      smc_pkg::SMC_RUN: begin
        if (sleep_go) begin
          state_nxt = smc_pkg::SMC_SLEEP;
          mode_nxt = sel_mode;
        end
      end
      smc_pkg::SMC_SLEEP: begin
        if (rst_evt) begin
          state_nxt = smc_pkg::SMC_RUN;
        end else if (wk.wake) begin
          // zero start-up skips straight to the halt cycles
          if (wake_delay == 16'h0000) begin
            state_nxt = smc_pkg::SMC_HALT;
            cnt_nxt = smc_pkg::SMC_HALT_CYC;
          end else begin
            state_nxt = smc_pkg::SMC_START;
            cnt_nxt = wake_delay;
          end
        end
      end
      smc_pkg::SMC_START: begin
        if (rst_evt) begin
          state_nxt = smc_pkg::SMC_RUN;
        end else if (cnt_r <= 16'h0001) begin
          // start-up elapsed, then the core halt
          state_nxt = smc_pkg::SMC_HALT;
          cnt_nxt = smc_pkg::SMC_HALT_CYC;
        end else begin
          cnt_nxt = cnt_r - 16'h0001;
        end
      end
      smc_pkg::SMC_HALT: begin
        if (rst_evt) begin
          state_nxt = smc_pkg::SMC_RUN;
        end else if (cnt_r <= 16'h0001) begin
          // four halt cycles done, handler may run
          state_nxt = smc_pkg::SMC_RUN;
          cnt_nxt = 16'h0000;
        end else begin
          cnt_nxt = cnt_r - 16'h0001;
        end
      end
      default: begin
        state_nxt = smc_pkg::SMC_RUN;
        cnt_nxt = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_r <= smc_pkg::SMC_CTRL_RST;
    end else if (ctrl_wr_i) begin
      ctrl_r <= ctrl_wdata_i;
    end
  end

  // sequencer state, count and latched mode
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= smc_pkg::SMC_RUN;
      cnt_r <= 16'h0000;
      mode_r <= smc_pkg::SMC_M_IDLE;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      mode_r <= mode_nxt;
    end
  end

  // clock enables follow the next state, so gating lands with it
  always_comb begin
    case (state_nxt)
      smc_pkg::SMC_SLEEP: ck_nxt = clk_map(mode_nxt, timer0_async_select_i,
                                           1'b1);
      smc_pkg::SMC_START: begin
        // oscillator restarts, domains stay gated until it settles
        ck_nxt = clk_map(mode_r, timer0_async_select_i, 1'b1);
        ck_nxt[smc_pkg::SMC_CK_OSC] = 1'b1;
      end
      default: ck_nxt = clk_map(mode_r, timer0_async_select_i, 1'b0);
    endcase
  end

  // only clocks are gated; no clear reaches core storage
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ck_r <= 7'h7e;
    end else begin
      ck_r <= ck_nxt;
    end
  end

  // core halt and sleep status
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      halt_r <= 1'b0;
      sleeping_r <= 1'b0;
    end else begin
      halt_r <= (state_nxt != smc_pkg::SMC_RUN);
      sleeping_r <= (state_nxt == smc_pkg::SMC_SLEEP);
    end
  end

  // one-cycle pulses toward the core
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      resume_r <= 1'b0;
      rvec_r <= 1'b0;
    end else begin
      // resume after sleep through the interrupt
      resume_r <= (state_r == smc_pkg::SMC_HALT) & ~rst_evt &
                  (cnt_r <= 16'h0001);
      // reset while asleep goes to the reset vector
      rvec_r <= (state_r != smc_pkg::SMC_RUN) & rst_evt;
    end
  end

  // conversion kick on entry to idle or noise-reduction
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      adc_r <= 1'b0;
    end else begin
      adc_r <= sleep_go & adc_en_i &
               ((sel_mode == smc_pkg::SMC_M_IDLE) |
                (sel_mode == smc_pkg::SMC_M_NOISE));
    end
  end

  // flag undefined async timer after a synchronous power-save
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      undef_r <= 1'b0;
    end else if (sleep_go) begin
      undef_r <= (sel_mode == smc_pkg::SMC_M_PSAVE) & ~timer0_async_select_i;
    end
  end

  // output drive, all from flops
  assign ctrl_rdata_o = ctrl_r;
  assign core_clk_en_o = ck_r[smc_pkg::SMC_CK_CORE];
  assign nvm_clk_en_o = ck_r[smc_pkg::SMC_CK_NVM];
  assign periph_clk_en_o = ck_r[smc_pkg::SMC_CK_PERIPH];
  assign conv_clk_en_o = ck_r[smc_pkg::SMC_CK_CONV];
  assign async_clk_en_o = ck_r[smc_pkg::SMC_CK_ASYNC];
  assign main_osc_en_o = ck_r[smc_pkg::SMC_CK_OSC];
  assign timer_osc_en_o = ck_r[smc_pkg::SMC_CK_TOSC];
  assign core_halt_o = halt_r;
  assign sleeping_o = sleeping_r;
  assign irq_resume_o = resume_r;
  assign reset_vec_o = rvec_r;
  assign adc_start_o = adc_r;
  assign async_undef_o = undef_r;

endmodule

// File: dv/smc_sleep_ctrl_asserts.sv
// concurrent checks on the ports of the sleep controller
`timescale 1ns/10ps
module smc_sleep_ctrl_asserts (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // stimulus at the ports
  input wire logic ctrl_wr_i,
  input wire logic [7:0] ctrl_wdata_i,
  input wire logic sleep_instr_i,
  input wire logic xtal_source_i,
  input wire logic adc_en_i,
  input wire logic irq_any_i,
  input wire logic twi_match_i,
  input wire logic [7:0] ext_lines_i,
  input wire logic [3:0] ext_level_hi_i,
  input wire logic ext_reset_i,
  input wire logic wdt_reset_i,
  input wire logic bod_reset_i,
  // design outputs
  input wire logic core_clk_en_o,
  input wire logic nvm_clk_en_o,
  input wire logic periph_clk_en_o,
  input wire logic conv_clk_en_o,
  input wire logic async_clk_en_o,
  input wire logic main_osc_en_o,
  input wire logic timer_osc_en_o,
  input wire logic [7:0] ctrl_rdata_o,
  input wire logic core_halt_o,
  input wire logic sleeping_o,
  input wire logic irq_resume_o,
  input wire logic reset_vec_o,
  input wire logic adc_start_o
);
  logic [2:0] mode;
  logic go, rst_ev, quiet;
  // mode field is scattered over bits 4:2, msb sits lowest
  assign mode = {ctrl_rdata_o[2], ctrl_rdata_o[4], ctrl_rdata_o[3]};
  assign go = sleep_instr_i && !core_halt_o;
  assign rst_ev = ext_reset_i || wdt_reset_i || bod_reset_i;
  // nothing that power-down accepts as a wake source
  assign quiet = !twi_match_i && !rst_ev && ext_lines_i[3:0] == 4'h0 &&
    (ext_lines_i[7:4] & ext_level_hi_i) == 4'h0;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  ctrl_write_a: assert property (
    ctrl_wr_i |=> ctrl_rdata_o == $past(ctrl_wdata_i))
    else $error("control register missed a write");
  enter_idle_a: assert property (
    go && ctrl_rdata_o[5] && mode == 3'h0 |=> sleeping_o && !core_clk_en_o &&
    !nvm_clk_en_o && periph_clk_en_o && conv_clk_en_o && main_osc_en_o &&
    adc_start_o == $past(adc_en_i))
    else $error("idle entry wrong");
  unarmed_sleep_a: assert property (
    go && !ctrl_rdata_o[5] |=> !sleeping_o && !core_halt_o)
    else $error("sleep taken while not armed");
  illegal_mode_a: assert property (
    go && (mode == 3'h4 || mode == 3'h5 || (mode[2] && !xtal_source_i))
    |=> !sleeping_o)
    else $error("illegal sleep mode entered");
  noise_map_a: assert property (
    sleeping_o && mode == 3'h1 |-> !periph_clk_en_o && !core_clk_en_o &&
    !nvm_clk_en_o && conv_clk_en_o && async_clk_en_o && main_osc_en_o)
    else $error("noise reduction clock map wrong");
  pdown_map_a: assert property (
    sleeping_o && mode == 3'h2 |-> !(core_clk_en_o || nvm_clk_en_o ||
    periph_clk_en_o || conv_clk_en_o || async_clk_en_o || main_osc_en_o ||
    timer_osc_en_o))
    else $error("power-down left a clock running");
  pdown_quiet_a: assert property (
    (sleeping_o && mode == 3'h2 && quiet) [*2] |=> sleeping_o)
    else $error("power-down woke without a legal source");
  idle_wake_a: assert property (
    sleeping_o && mode == 3'h0 && $rose(irq_any_i) |->
    ##1 core_halt_o [*5] ##1 (irq_resume_o && !core_halt_o))
    else $error("idle wake sequence wrong");
  reset_wake_a: assert property (
    sleeping_o && rst_ev |-> ##[1:3] reset_vec_o)
    else $error("reset during sleep gave no reset vector");
  sleep_halts_a: assert property (
    sleeping_o |-> core_halt_o && !irq_resume_o)
    else $error("core not held while sleeping");

  cover property (sleeping_o && mode == 3'h3);
  cover property (reset_vec_o);
  cover property (irq_resume_o);
endmodule

// File: dv/smc_core_model.sv
// behavioural core: executes sleep and counts handler entries
`timescale 1ns/10ps
module smc_core_model (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // handshake with the controller
  input wire logic irq_resume_i,
  output logic sleep_instr_o
);
  int n_resume;

  initial sleep_instr_o = 1'h0;

  task automatic exec_sleep();
    @(negedge ref_clk_i);
    sleep_instr_o = 1'h1;
    @(negedge ref_clk_i);
    sleep_instr_o = 1'h0;
  endtask

  // handler entry counted per resume pulse
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      n_resume <= 0;
    end else if (irq_resume_i === 1'h1) begin
      n_resume <= n_resume + 1;
    end
  end
endmodule

// File: dv/test_sleep_mode_clock_gating.sv
// self-checking bench of the sleep mode clock gating controller
`timescale 1ns/10ps
module test_sleep_mode_clock_gating;
  typedef struct packed {
    logic arm;
    logic [2:0] mode;
    logic tasync;
    logic xtal;
    logic slp;
    logic [6:0] map;
  } smc_row_t;
  logic ref_clk_i, rstn_i, ctrl_wr_i, sleep_instr_i, xtal_source_i;
  logic timer0_async_select_i, adc_en_i, irq_any_i, adc_done_i, twi_match_i;
  logic spm_ee_rdy_i, t0_ovf_i, t0_cmp_i, t0_ovf_en_i, t0_cmp_en_i;
  logic global_ie_i, ext_reset_i, wdt_reset_i, bod_reset_i;
  logic [7:0] ctrl_wdata_i, ext_lines_i, ctrl_rdata_o;
  logic [3:0] ext_level_hi_i;
  logic [15:0] startup_ck_i;
  logic core_clk_en_o, nvm_clk_en_o, periph_clk_en_o, conv_clk_en_o;
  logic async_clk_en_o, main_osc_en_o, timer_osc_en_o, core_halt_o;
  logic sleeping_o, irq_resume_o, reset_vec_o, adc_start_o, async_undef_o;
  logic [6:0] map;
  int failures, n_checks, cycles, cnt, n0;
  smc_row_t r;
  // mode, timer select, crystal, expected sleep and clock map
  smc_row_t rows [11] = '{
    '{1'h1, 3'h0, 1'h1, 1'h0, 1'h1, 7'h1f}, '{1'h1, 3'h1, 1'h0, 1'h0, 1'h1, 7'h0e},
    '{1'h1, 3'h2, 1'h1, 1'h0, 1'h1, 7'h00}, '{1'h1, 3'h3, 1'h1, 1'h0, 1'h1, 7'h05},
    '{1'h1, 3'h3, 1'h0, 1'h0, 1'h1, 7'h00}, '{1'h1, 3'h6, 1'h0, 1'h1, 1'h1, 7'h02},
    '{1'h1, 3'h7, 1'h1, 1'h1, 1'h1, 7'h07}, '{1'h1, 3'h4, 1'h0, 1'h1, 1'h0, 7'h7e},
    '{1'h1, 3'h5, 1'h1, 1'h1, 1'h0, 7'h7f}, '{1'h1, 3'h6, 1'h0, 1'h0, 1'h0, 7'h7e},
    '{1'h0, 3'h0, 1'h1, 1'h0, 1'h0, 7'h7f}};

  assign map = {core_clk_en_o, nvm_clk_en_o, periph_clk_en_o, conv_clk_en_o,
    async_clk_en_o, main_osc_en_o, timer_osc_en_o};

  smc_sleep_ctrl dut (.ref_clk_i, .rstn_i, .ctrl_wr_i, .ctrl_wdata_i,
    .sleep_instr_i, .xtal_source_i, .startup_ck_i, .timer0_async_select_i,
    .adc_en_i, .irq_any_i, .adc_done_i, .twi_match_i, .spm_ee_rdy_i,
    .ext_lines_i, .ext_level_hi_i, .t0_ovf_i, .t0_cmp_i, .t0_ovf_en_i,
    .t0_cmp_en_i, .global_ie_i, .ext_reset_i, .wdt_reset_i, .bod_reset_i,
    .core_clk_en_o, .nvm_clk_en_o, .periph_clk_en_o, .conv_clk_en_o,
    .async_clk_en_o, .main_osc_en_o, .timer_osc_en_o, .ctrl_rdata_o,
    .core_halt_o, .sleeping_o, .irq_resume_o, .reset_vec_o, .adc_start_o,
    .async_undef_o);
  smc_core_model core (.ref_clk_i, .rstn_i, .irq_resume_i(irq_resume_o),
    .sleep_instr_o(sleep_instr_i));

  // comparison with count and report
  task automatic check(input string what, input logic [31:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  function automatic logic [7:0] enc(input logic arm, input logic [2:0] m);
    return {2'h0, arm, m[1], m[0], m[2], 2'h0};
  endfunction

  // extra wait before the four halt cycles
  function automatic logic [15:0] extra(input logic [2:0] m);
    if (m == 3'h2 || m == 3'h3) return startup_ck_i;
    if (m[2]) return 16'h0006;
    return 16'h0000;
  endfunction

  task automatic wr_ctrl(input logic [7:0] v);
    @(negedge ref_clk_i);
    ctrl_wr_i = 1'h1;
    ctrl_wdata_i = v;
    @(negedge ref_clk_i);
    ctrl_wr_i = 1'h0;
    check("control reg", v, ctrl_rdata_o);
  endtask

  // counts falling edges until the resume pulse
  task automatic wait_resume();
    cnt = 0;
    do begin
      @(negedge ref_clk_i);
      cnt++;
      // sources held over one sampling edge
      {twi_match_i, irq_any_i, adc_done_i, t0_ovf_i} = 4'h0;
      ext_lines_i = 8'h00;
    end while (irq_resume_o !== 1'h1 && cnt < 60);
  endtask

  initial begin
    ref_clk_i = 1'h0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // hang guard; the whole run needs well under a thousand cycles
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      $display("timeout after %0d cycles", cycles);
      test_done();
    end
  end

  initial begin
    {rstn_i, ctrl_wr_i, xtal_source_i, timer0_async_select_i, adc_en_i} = '0;
    {irq_any_i, adc_done_i, twi_match_i, spm_ee_rdy_i, t0_ovf_i} = '0;
    {t0_cmp_i, t0_ovf_en_i, t0_cmp_en_i, global_ie_i, ext_reset_i} = '0;
    {wdt_reset_i, bod_reset_i, ctrl_wdata_i, ext_lines_i, ext_level_hi_i} = '0;
    startup_ck_i = 16'h0008;
    repeat (16) @(negedge ref_clk_i);
    rstn_i = 1'h1;
    @(negedge ref_clk_i);
    check("reset ctrl", 8'h00, ctrl_rdata_o);
    check("reset clocks", 7'h7e, map);
    $display("reset values done");
    adc_en_i = 1'h1;
    foreach (rows[i]) begin
      r = rows[i];
      timer0_async_select_i = r.tasync;
      xtal_source_i = r.xtal;
      wr_ctrl(enc(r.arm, r.mode));
      core.exec_sleep();
      check("sleeping", r.slp, sleeping_o);
      check("clock map", r.map, map);
      check("conv start", r.slp && r.mode < 3'h2, adc_start_o);
      if (r.slp) begin
        check("async undef", r.mode == 3'h3 && !r.tasync, async_undef_o);
        twi_match_i = 1'h1;
        wait_resume();
        check("wake cycles", 6 + extra(r.mode), cnt);
        check("halt after wake", 1'h0, core_halt_o);
      end
      $display("mode row %0d done", i);
    end
    // edge on line 4, any irq and conversion done must not end power-down
    wr_ctrl(enc(1'h1, 3'h2));
    core.exec_sleep();
    {ext_lines_i, irq_any_i, adc_done_i} = {8'h10, 2'h3};
    repeat (4) @(negedge ref_clk_i);
    check("pdown held", 1'h1, sleeping_o);
    ext_level_hi_i = 4'h1;
    wait_resume();
    check("level wake", 6 + startup_ck_i, cnt);
    ext_level_hi_i = 4'h0;
    $display("power-down sources done");
    // timer 0 wakes power-save only with the global enable set
    timer0_async_select_i = 1'h1;
    t0_ovf_en_i = 1'h1;
    wr_ctrl(enc(1'h1, 3'h3));
    core.exec_sleep();
    t0_ovf_i = 1'h1;
    repeat (4) @(negedge ref_clk_i);
    check("psave held", 1'h1, sleeping_o);
    global_ie_i = 1'h1;
    wait_resume();
    check("timer wake", 6 + startup_ck_i, cnt);
    $display("power-save timer done");
    // any pending interrupt ends idle
    wr_ctrl(enc(1'h1, 3'h0));
    core.exec_sleep();
    irq_any_i = 1'h1;
    wait_resume();
    check("idle wake", 6, cnt);
    $display("idle wake done");
    // each reset source during sleep goes to the reset vector
    for (int k = 0; k < 3; k++) begin
      wr_ctrl(enc(1'h1, 3'(k)));
      core.exec_sleep();
      n0 = core.n_resume;
      {ext_reset_i, wdt_reset_i, bod_reset_i} = 3'h4 >> k;
      @(negedge ref_clk_i);
      {ext_reset_i, wdt_reset_i, bod_reset_i} = 3'h0;
      // the pulse already stands at this negedge, so look before waiting
      cnt = 0;
      repeat (4) begin
        if (reset_vec_o === 1'h1) cnt++;
        @(negedge ref_clk_i);
      end
      check("reset vector", 1, cnt);
      check("no resume", n0, core.n_resume);
      check("halt released", 1'h0, core_halt_o);
    end
    $display("reset wake done");
    // reset in mid-run clears the register and forces all clocks but the timer osc on
    wr_ctrl(enc(1'h1, 3'h2));
    @(negedge ref_clk_i);
    rstn_i = 1'h0;
    #1;
    check("ctrl cleared", 8'h00, ctrl_rdata_o);
    check("clocks in reset", 7'h7e, map);
    @(negedge ref_clk_i);
    rstn_i = 1'h1;
    @(negedge ref_clk_i);
    check("timer osc follows", 7'h7f, map);
    $display("second reset done");
    test_done();
  end
endmodule

bind smc_sleep_ctrl smc_sleep_ctrl_asserts u_chk (.ref_clk_i, .rstn_i,
  .ctrl_wr_i, .ctrl_wdata_i, .sleep_instr_i, .xtal_source_i, .adc_en_i,
  .irq_any_i, .twi_match_i, .ext_lines_i, .ext_level_hi_i, .ext_reset_i,
  .wdt_reset_i, .bod_reset_i, .core_clk_en_o, .nvm_clk_en_o,
  .periph_clk_en_o, .conv_clk_en_o, .async_clk_en_o, .main_osc_en_o,
  .timer_osc_en_o, .ctrl_rdata_o, .core_halt_o, .sleeping_o, .irq_resume_o,
  .reset_vec_o, .adc_start_o);
